// [hdl/cet_cfg.svh]
// clock figures for the execution timing model, in processor clocks
// assumes two-clock reads and writes on the external bus
`ifndef CET_CFG_SVH
`define CET_CFG_SVH
`define CET_ZERO_CLK      8'h00
`define CET_LONG_EXTRA    8'h02
`define CET_REG_CLK       8'h02
`define CET_MEM_WR_CLK    8'h05
`define CET_MEM_WR_TAIL   8'h03
`define CET_SAVE_CLK      8'h03
`define CET_SAVE_EDGE     8'h01
`define CET_OP_HEAD       8'h02
`define CET_CMP2_MIN      8'h10
`define CET_CMP2_MAX      8'h12
`define CET_WMUL_CLK      8'h1A
`define CET_LMUL_MIN      8'h2E
`define CET_LMUL_MAX      8'h34
`define CET_WDIVU_CLK     8'h20
`define CET_WDIVS_CLK     8'h2A
`define CET_LDIVU_MAX     8'h2E
`define CET_LDIVS_MAX     8'h3E
`define CET_TBLR_HEAD     8'h1A
`define CET_TBLN_HEAD     8'h1E
`define CET_TBLR_MIN      8'h1C
`define CET_TBLR_MAX      8'h1E
`define CET_TABLE_LOOKUP_SIGNED_UNROUNDED_MIN     8'h1E
`define CET_TABLE_LOOKUP_SIGNED_UNROUNDED_MAX     8'h22
`define CET_TABLE_LOOKUP_UNSIGNED_UNROUNDED_MIN     8'h22
`define CET_TABLE_LOOKUP_UNSIGNED_UNROUNDED_MAX     8'h28
`define CET_TBLM_HEAD     8'h06
`define CET_TBLRM_MIN     8'h21
`define CET_TBLRM_MAX     8'h23
`define CET_TBLSNM_MIN    8'h23
`define CET_TBLSNM_MAX    8'h27
`define CET_TBLUNM_MIN    8'h27
`define CET_TBLUNM_MAX    8'h2D
`define CET_BCD_REG_CLK   8'h04
`define CET_BCD_MEM_CLK   8'h0C
`define CET_EXT_MEM_CLK   8'h0A
`define CET_MEMORY_COMPARE_POSTINC_CLK      8'h08
`define CET_TAS_REG_CLK   8'h06
`define CET_TAS_REG_HEAD  8'h04
`define CET_TAS_MEM_CLK   8'h0A
`define CET_SHIFT_CLK     8'h06
`define CET_SHIFT_HEAD    8'h04
`define CET_ALTERNATE_SPACE_MOVE_LD_HEAD 8'h07
`define CET_ALTERNATE_SPACE_MOVE_LD_CLK  8'h0B
`define CET_ALTERNATE_SPACE_MOVE_ST_HEAD 8'h09
`define CET_ALTERNATE_SPACE_MOVE_ST_CLK  8'h0C
`define CET_SHIFT_FLOOR   8'h06
`define CET_SHREG_BASE    8'h03
`define CET_XROT_REG_BASE 8'h03
`define CET_XROT_IMM_BASE 8'h02
`define CET_XROT_IMM_MAX  8'h08
`endif

// [hdl/cet_combine.sv]
// joins the timing so far with the next step, overlapping tail and head
// steps arrive in execution order
`timescale 1ns/1ps
module cet_combine (
  // link to sequencer
  cet_link_if.combiner lnk
);
  import cet_pkg::*;

  function automatic logic [7:0] posPart(input logic signed [7:0] v);
    posPart = v[7] ? 8'h00 : v;
  endfunction : posPart

  logic [7:0] tailP;
  logic [7:0] headP;
  logic [7:0] ovl;

  always_comb
  begin
    tailP = posPart(lnk.accIn.tail);
    headP = posPart(lnk.stepIn.head);
    ovl   = (tailP < headP) ? tailP : headP;
    if (lnk.accEmpty)
    begin
      lnk.accOut = lnk.stepIn;
    end
    else
    begin
      // earlier step's tail hides under the next step's head
      lnk.accOut.head   = lnk.accIn.head;
      lnk.accOut.tail   = lnk.stepIn.tail;
      lnk.accOut.totMin = lnk.accIn.totMin + lnk.stepIn.totMin - ovl;
      lnk.accOut.totMax = lnk.accIn.totMax + lnk.stepIn.totMax - ovl;
      lnk.accOut.reads  = lnk.accIn.reads + lnk.stepIn.reads;
      lnk.accOut.pref   = lnk.accIn.pref + lnk.stepIn.pref;
      lnk.accOut.writes = lnk.accIn.writes + lnk.stepIn.writes;
    end
  end
endmodule : cet_combine

// [hdl/cet_exec_timing.sv]
// execution timing model: per instruction form, head, tail, total clocks and bus cycles
// caller supplies effective-address and immediate-fetch times; one request at a time
//
// Summary of operation
// - long operand doubles the bus cycles its entry marks long and adds two clocks per added bus cycle to tail and total
// - marked instructions tolerate four-clock bus cycles without longer total time
// - long multiply and divide skip the save step when source is a data register
// - signed and unsigned multiply take equal time; unsigned table lookup takes longer than signed
// - shift time ignores count except register-count and extended-rotate forms
// - alternate-space move runs save, then address, then operation steps
// - register add, subtract, compare take 2 clocks, head and tail zero
// - memory write-back operations take 5 clocks, head 0, tail 3
// - word multiply takes 26 clocks, head and tail zero
// - long multiply step takes 46-52 single or 46 pair, head 2
// - word divide takes 32 unsigned, 42 signed clocks
// - long divide step takes at most 46 unsigned, 62 signed clocks
// - register table lookup takes 28-30, 30-34 or 34-40 clocks, two prefetches
// - decimal add and subtract take 4 register or 12 memory clocks
// - extend add and subtract take 2 register or 10 memory clocks
// - memory compare postincrement takes 8 clocks, head 1, two reads
// - test-and-set takes 6 clocks on register, 10 on memory
// - immediate-count register shift or rotate takes 6 clocks, head 4
// - memory shift or rotate takes 6 clocks, head 0, tail 2
// - immediate arithmetic adds an immediate-fetch address time
// - extended rotate by register count takes max of 6 and formula
`timescale 1ns/1ps
`include "cet_cfg.svh"
module cet_exec_timing #(
  parameter int COUNT_W = 6
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // request
  input  wire logic              reqValid,
  input  wire cet_pkg::cet_op_e  reqOp,
  input  wire logic              reqLong,
  input  wire logic              reqSrcDataReg,
  input  wire logic [COUNT_W-1:0] reqCount,
  input  wire cet_pkg::cet_time_s reqEaTime,
  input  wire cet_pkg::cet_time_s reqImmTime,
  // answer
  output logic                   reqReady,
  output logic                   ansValid,
  output logic signed [7:0]      ansHead,
  output logic signed [7:0]      ansTail,
  output logic [7:0]             ansTotalMin,
  output logic [7:0]             ansTotalMax,
  output logic [3:0]             ansReads,
  output logic [3:0]             ansPrefetch,
  output logic [3:0]             ansWrites,
  output logic                   ansUpperBound,
  output logic                   ansBusTolerant,
  output logic                   ansSaveRun
);
  import cet_pkg::*;

  if (COUNT_W != 6)
  begin : g_chk
    $error("COUNT_W must be 6");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_SAVE, ST_IMM, ST_EA, ST_OP} cet_state_e;

  function automatic cet_time_s mk(input logic [7:0] h, input logic [7:0] t, input logic [7:0] mn,
                                   input logic [7:0] mx, input logic [3:0] r, input logic [3:0] p,
                                   input logic [3:0] w);
    mk = '{head: h, tail: t, totMin: mn, totMax: mx, reads: r, pref: p, writes: w};
  endfunction : mk

  function automatic cet_entry_s entryOf(input cet_op_e op);
    cet_entry_s e;
    e = '{base: mk(`CET_ZERO_CLK, `CET_ZERO_CLK, `CET_REG_CLK, `CET_REG_CLK, 4'h0, 4'h1, 4'h0),
          longRd: 2'h0, longWr: 2'h0, hasSave: 1'b0, needsEa: 1'b0, needsImm: 1'b0,
          upper: 1'b0, tolerant: 1'b0, shift: SH_NONE};
    unique case (op)
      OP_ALU_REG, OP_EXT_REG: ;
      OP_ALU_FEA_REG:
        e.needsEa = 1'b1;
      OP_ALU_MEM, OP_SINGLE_MEM, OP_IMM_MEM:
      begin
        e.base = mk(`CET_ZERO_CLK, `CET_MEM_WR_TAIL, `CET_MEM_WR_CLK, `CET_MEM_WR_CLK, 4'h0, 4'h1, 4'h1);
        e.longWr   = 2'h1;
        e.needsEa  = 1'b1;
        e.needsImm = (op == OP_IMM_MEM);
      end
      OP_IMM_REG:
        e.needsImm = 1'b1;
      OP_CMP2:
      begin
        e.base = mk(`CET_OP_HEAD, `CET_ZERO_CLK, `CET_CMP2_MIN, `CET_CMP2_MAX, 4'h1, 4'h1, 4'h0);
        e.longRd = 2'h1;
        e.hasSave = 1'b1;
        e.needsEa = 1'b1;
        e.tolerant = 1'b1;
      end
      OP_WORD_MUL:
      begin
        e.base = mk(`CET_ZERO_CLK, `CET_ZERO_CLK, `CET_WMUL_CLK, `CET_WMUL_CLK, 4'h0, 4'h1, 4'h0);
        e.needsEa = 1'b1;
      end
      OP_LONG_MUL_ONE, OP_LONG_MUL_PAIR:
      begin
        e.base = mk(`CET_OP_HEAD, `CET_ZERO_CLK, `CET_LMUL_MIN,
                    (op == OP_LONG_MUL_ONE) ? `CET_LMUL_MAX : `CET_LMUL_MIN, 4'h0, 4'h1, 4'h0);
        e.hasSave = 1'b1;
        e.needsEa = 1'b1;
        e.tolerant = 1'b1;
      end
      OP_WORD_DIVU, OP_WORD_DIVS:
      begin
        e.base = mk(`CET_ZERO_CLK, `CET_ZERO_CLK, (op == OP_WORD_DIVU) ? `CET_WDIVU_CLK : `CET_WDIVS_CLK,
                    (op == OP_WORD_DIVU) ? `CET_WDIVU_CLK : `CET_WDIVS_CLK, 4'h0, 4'h1, 4'h0);
        e.needsEa = 1'b1;
      end
      OP_LONG_DIVU, OP_LONG_DIVS:
      begin
        e.base = mk(`CET_OP_HEAD, `CET_ZERO_CLK, (op == OP_LONG_DIVU) ? `CET_LDIVU_MAX : `CET_LDIVS_MAX,
                    (op == OP_LONG_DIVU) ? `CET_LDIVU_MAX : `CET_LDIVS_MAX, 4'h0, 4'h1, 4'h0);
        e.upper = 1'b1;
        e.hasSave = 1'b1;
        e.needsEa = 1'b1;
        e.tolerant = 1'b1;
      end
      OP_TBL_R_REG:
        e.base = mk(`CET_TBLR_HEAD, `CET_ZERO_CLK, `CET_TBLR_MIN, `CET_TBLR_MAX, 4'h0, 4'h2, 4'h0);
      OP_TBL_SN_REG:
        e.base = mk(`CET_TBLN_HEAD, `CET_ZERO_CLK, `CET_TABLE_LOOKUP_SIGNED_UNROUNDED_MIN, `CET_TABLE_LOOKUP_SIGNED_UNROUNDED_MAX, 4'h0, 4'h2, 4'h0);
      OP_TBL_UN_REG:
        e.base = mk(`CET_TBLN_HEAD, `CET_ZERO_CLK, `CET_TABLE_LOOKUP_UNSIGNED_UNROUNDED_MIN, `CET_TABLE_LOOKUP_UNSIGNED_UNROUNDED_MAX, 4'h0, 4'h2, 4'h0);
      OP_TBL_R_MEM, OP_TBL_SN_MEM, OP_TBL_UN_MEM:
      begin
        unique case (op)
          OP_TBL_R_MEM:
            e.base = mk(`CET_TBLM_HEAD, `CET_ZERO_CLK, `CET_TBLRM_MIN, `CET_TBLRM_MAX, 4'h2, 4'h1, 4'h0);
          OP_TBL_SN_MEM:
            e.base = mk(`CET_TBLM_HEAD, `CET_ZERO_CLK, `CET_TBLSNM_MIN, `CET_TBLSNM_MAX, 4'h2, 4'h1, 4'h0);
          default:
            e.base = mk(`CET_TBLM_HEAD, `CET_ZERO_CLK, `CET_TBLUNM_MIN, `CET_TBLUNM_MAX, 4'h2, 4'h1, 4'h0);
        endcase
        e.longRd = 2'h2;
        e.hasSave = 1'b1;
        e.needsEa = 1'b1;
        e.tolerant = 1'b1;
      end
      OP_BCD_REG:
        e.base = mk(`CET_OP_HEAD, `CET_ZERO_CLK, `CET_BCD_REG_CLK, `CET_BCD_REG_CLK, 4'h0, 4'h1, 4'h0);
      OP_BCD_MEM:
        e.base = mk(`CET_OP_HEAD, `CET_OP_HEAD, `CET_BCD_MEM_CLK, `CET_BCD_MEM_CLK, 4'h2, 4'h1, 4'h1);
      OP_EXT_MEM:
        e.base = mk(`CET_OP_HEAD, `CET_OP_HEAD, `CET_EXT_MEM_CLK, `CET_EXT_MEM_CLK, 4'h2, 4'h1, 4'h1);
      OP_MEMORY_COMPARE_POSTINC:
        e.base = mk(`CET_SAVE_EDGE, `CET_ZERO_CLK, `CET_MEMORY_COMPARE_POSTINC_CLK, `CET_MEMORY_COMPARE_POSTINC_CLK, 4'h2, 4'h1, 4'h0);
      OP_TAS_REG:
        e.base = mk(`CET_TAS_REG_HEAD, `CET_ZERO_CLK, `CET_TAS_REG_CLK,
                    `CET_TAS_REG_CLK, 4'h0, 4'h1, 4'h0);
      OP_TAS_MEM:
      begin
        e.base = mk(`CET_SAVE_EDGE, `CET_ZERO_CLK, `CET_TAS_MEM_CLK, `CET_TAS_MEM_CLK, 4'h0, 4'h1, 4'h1);
        e.needsEa = 1'b1;
      end
      OP_SHIFT_IMM:
        e.base = mk(`CET_SHIFT_HEAD, `CET_ZERO_CLK, `CET_SHIFT_CLK, `CET_SHIFT_CLK, 4'h0, 4'h1, 4'h0);
      OP_SHIFT_MEM:
      begin
        e.base = mk(`CET_ZERO_CLK, `CET_OP_HEAD, `CET_SHIFT_CLK, `CET_SHIFT_CLK, 4'h0, 4'h1, 4'h1);
        e.needsEa = 1'b1;
      end
      OP_SHIFT_REG:
        e.shift = SH_REG_CNT;
      OP_XROT_REG:
        e.shift = SH_XROT_REG;
      OP_XROT_IMM:
        e.shift = SH_XROT_IMM;
      OP_ALTERNATE_SPACE_MOVE_LOAD, OP_ALTERNATE_SPACE_MOVE_STORE:
      begin
        if (op == OP_ALTERNATE_SPACE_MOVE_LOAD)
        begin
          e.base = mk(`CET_ALTERNATE_SPACE_MOVE_LD_HEAD, `CET_SAVE_EDGE, `CET_ALTERNATE_SPACE_MOVE_LD_CLK, `CET_ALTERNATE_SPACE_MOVE_LD_CLK, 4'h1, 4'h1, 4'h0);
          e.longRd = 2'h1;
        end
        else
        begin
          e.base = mk(`CET_ALTERNATE_SPACE_MOVE_ST_HEAD, `CET_OP_HEAD, `CET_ALTERNATE_SPACE_MOVE_ST_CLK, `CET_ALTERNATE_SPACE_MOVE_ST_CLK, 4'h0, 4'h1, 4'h1);
          e.longWr = 2'h1;
        end
        e.hasSave = 1'b1;
        e.needsEa = 1'b1;
      end
    endcase
    entryOf = e;
  endfunction : entryOf

  // request latch and sequencer state
  cet_state_e       state_reg, state_next;
  cet_op_e          op_reg, op_next;
  logic             long_reg, long_next;
  logic             srcD_reg, srcD_next;
  logic [5:0]       count_reg, count_next;
  cet_time_s        ea_reg, ea_next;
  cet_time_s        imm_reg, imm_next;
  cet_time_s        acc_reg, acc_next;
  logic             empty_reg, empty_next;
  logic             saved_reg, saved_next;
  // answer registers
  logic             ready_reg, ready_next;
  logic             valid_reg, valid_next;
  cet_time_s        ans_reg, ans_next;
  logic             upper_reg, upper_next;
  logic             tol_reg, tol_next;
  logic             saveRun_reg, saveRun_next;

  cet_entry_s       ent;
  cet_time_s        opStep;
  logic             useStep;
  logic             skipSave;

  cet_link_if lnk ();

  cet_shift_calc u_shift (
    .lnk (lnk.shifter)
  );

  cet_combine u_comb (
    .lnk (lnk.combiner)
  );

  always_comb
  begin
    ent      = entryOf(op_reg);
    skipSave = srcD_reg && (ent.longRd == 2'h0) && (op_reg inside {OP_LONG_MUL_ONE, OP_LONG_MUL_PAIR,
               OP_LONG_DIVU, OP_LONG_DIVS});
    opStep   = ent.base;
    if (ent.shift != SH_NONE)
    begin
      opStep.head   = lnk.shClocks;
      opStep.totMin = lnk.shClocks;
      opStep.totMax = lnk.shClocks;
    end
    if (long_reg)
    begin
      // each long operand cycle becomes two bus cycles
      opStep.reads  = opStep.reads + {2'h0, ent.longRd};
      opStep.writes = opStep.writes + {2'h0, ent.longWr};
      opStep.tail   = opStep.tail + (`CET_LONG_EXTRA * ({6'h00, ent.longRd} + {6'h00, ent.longWr}));
      opStep.totMin = opStep.totMin + (`CET_LONG_EXTRA * ({6'h00, ent.longRd} + {6'h00, ent.longWr}));
      opStep.totMax = opStep.totMax + (`CET_LONG_EXTRA * ({6'h00, ent.longRd} + {6'h00, ent.longWr}));
    end
    lnk.shKind   = ent.shift;
    lnk.shCount  = count_reg;
    lnk.accIn    = acc_reg;
    lnk.accEmpty = empty_reg;
    lnk.stepIn   = opStep;
    useStep      = 1'b0;
    unique case (state_reg)
      ST_SAVE:
      begin
        lnk.stepIn = mk(`CET_SAVE_EDGE, `CET_SAVE_EDGE, `CET_SAVE_CLK, `CET_SAVE_CLK, 4'h0, 4'h1, 4'h0);
        useStep    = ent.hasSave && !skipSave;
      end
      ST_IMM:
      begin
        lnk.stepIn = imm_reg;
        useStep    = ent.needsImm;
      end
      ST_EA:
      begin
        lnk.stepIn = ea_reg;
        useStep    = ent.needsEa;
      end
      ST_OP:
        useStep = 1'b1;
      ST_IDLE: ;
    endcase
  end

  always_comb
  begin
    state_next   = state_reg;
    op_next      = op_reg;
    long_next    = long_reg;
    srcD_next    = srcD_reg;
    count_next   = count_reg;
    ea_next      = ea_reg;
    imm_next     = imm_reg;
    acc_next     = useStep ? lnk.accOut : acc_reg;
    empty_next   = empty_reg && !useStep;
    saved_next   = saved_reg || ((state_reg == ST_SAVE) && useStep);
    valid_next   = 1'b0;
    ans_next     = ans_reg;
    upper_next   = upper_reg;
    tol_next     = tol_reg;
    saveRun_next = saveRun_reg;
    unique case (state_reg)
      ST_IDLE:
        if (reqValid)
        begin
          state_next = ST_SAVE;
          op_next    = reqOp;
          long_next  = reqLong;
          srcD_next  = reqSrcDataReg;
          count_next = reqCount;
          ea_next    = reqEaTime;
          imm_next   = reqImmTime;
          empty_next = 1'b1;
          saved_next = 1'b0;
        end
      ST_SAVE:
        state_next = ST_IMM;
      ST_IMM:
        state_next = ST_EA;
      ST_EA:
        state_next = ST_OP;
      ST_OP:
      begin
        state_next   = ST_IDLE;
        valid_next   = 1'b1;
        ans_next     = lnk.accOut;
        upper_next   = ent.upper;
        tol_next     = ent.tolerant && !skipSave;
        saveRun_next = saved_reg;
      end
    endcase
    ready_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg   <= ST_IDLE;
      op_reg      <= OP_ALU_REG;
      long_reg    <= 1'b0;
      srcD_reg    <= 1'b0;
      count_reg   <= 6'h00;
      ea_reg      <= '0;
      imm_reg     <= '0;
      acc_reg     <= '0;
      empty_reg   <= 1'b1;
      saved_reg   <= 1'b0;
      ready_reg   <= 1'b0;
      valid_reg   <= 1'b0;
      ans_reg     <= '0;
      upper_reg   <= 1'b0;
      tol_reg     <= 1'b0;
      saveRun_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      long_reg    <= long_next;
      srcD_reg    <= srcD_next;
      count_reg   <= count_next;
      ea_reg      <= ea_next;
      imm_reg     <= imm_next;
      acc_reg     <= acc_next;
      empty_reg   <= empty_next;
      saved_reg   <= saved_next;
      ready_reg   <= ready_next;
      valid_reg   <= valid_next;
      ans_reg     <= ans_next;
      upper_reg   <= upper_next;
      tol_reg     <= tol_next;
      saveRun_reg <= saveRun_next;
    end
  end

  assign reqReady       = ready_reg;
  assign ansValid       = valid_reg;
  assign ansHead        = ans_reg.head;
  assign ansTail        = ans_reg.tail;
  assign ansTotalMin    = ans_reg.totMin;
  assign ansTotalMax    = ans_reg.totMax;
  assign ansReads       = ans_reg.reads;
  assign ansPrefetch    = ans_reg.pref;
  assign ansWrites      = ans_reg.writes;
  assign ansUpperBound  = upper_reg;
  assign ansBusTolerant = tol_reg;
  assign ansSaveRun     = saveRun_reg;
endmodule : cet_exec_timing

// [hdl/cet_link_if.sv]
// links the sequencer to its shift-time and step-combining helpers
// purely combinational, no clock
`timescale 1ns/1ps
interface cet_link_if;
  import cet_pkg::*;
  cet_shift_e shKind;
  logic [5:0] shCount;
  logic [7:0] shClocks;
  cet_time_s  accIn;
  cet_time_s  stepIn;
  cet_time_s  accOut;
  logic       accEmpty;
  modport core     (output shKind, shCount, accIn, stepIn, accEmpty, input shClocks, accOut);
  modport shifter  (input shKind, shCount, output shClocks);
  modport combiner (input accIn, stepIn, accEmpty, output accOut);
endinterface : cet_link_if

// [hdl/cet_pkg.sv]
// types shared by the execution timing model
// no surroundings assumed
package cet_pkg;
  typedef enum logic [5:0] {
    OP_ALU_REG, OP_ALU_FEA_REG, OP_ALU_MEM, OP_IMM_REG, OP_IMM_MEM, OP_SINGLE_MEM,
    OP_CMP2, OP_WORD_MUL, OP_LONG_MUL_ONE, OP_LONG_MUL_PAIR, OP_WORD_DIVU, OP_WORD_DIVS,
    OP_LONG_DIVU, OP_LONG_DIVS, OP_TBL_R_REG, OP_TBL_SN_REG, OP_TBL_UN_REG,
    OP_TBL_R_MEM, OP_TBL_SN_MEM, OP_TBL_UN_MEM, OP_BCD_REG, OP_BCD_MEM, OP_EXT_REG,
    OP_EXT_MEM, OP_MEMORY_COMPARE_POSTINC, OP_TAS_REG, OP_TAS_MEM, OP_SHIFT_IMM, OP_SHIFT_MEM,
    OP_SHIFT_REG, OP_XROT_REG, OP_XROT_IMM, OP_ALTERNATE_SPACE_MOVE_LOAD, OP_ALTERNATE_SPACE_MOVE_STORE
  } cet_op_e;

  typedef enum logic [1:0] {SH_NONE, SH_REG_CNT, SH_XROT_REG, SH_XROT_IMM} cet_shift_e;

  typedef struct packed {
    logic signed [7:0] head;
    logic signed [7:0] tail;
    logic [7:0]        totMin;
    logic [7:0]        totMax;
    logic [3:0]        reads;
    logic [3:0]        pref;
    logic [3:0]        writes;
  } cet_time_s;

  typedef struct packed {
    cet_time_s  base;
    logic [1:0] longRd;
    logic [1:0] longWr;
    logic       hasSave;
    logic       needsEa;
    logic       needsImm;
    logic       upper;
    logic       tolerant;
    cet_shift_e shift;
  } cet_entry_s;
endpackage : cet_pkg

// [hdl/cet_shift_calc.sv]
// count-dependent shift and rotate time
// count arrives already latched by the sequencer
`timescale 1ns/1ps
`include "cet_cfg.svh"
module cet_shift_calc (
  // link to sequencer
  cet_link_if.shifter lnk
);
  import cet_pkg::*;

  function automatic logic [7:0] floorSix(input logic [7:0] v);
    floorSix = (v < `CET_SHIFT_FLOOR) ? `CET_SHIFT_FLOOR : v;
  endfunction : floorSix

  logic [7:0] n;
  logic [7:0] q;
  logic [7:0] m;
  logic [7:0] ni;

  always_comb
  begin
    n  = {2'h0, lnk.shCount};
    q  = {4'h0, lnk.shCount[5:2]};
    m  = {6'h0, lnk.shCount[1:0]};
    ni = (n > `CET_XROT_IMM_MAX) ? `CET_XROT_IMM_MAX : n;
    unique case (lnk.shKind)
      SH_REG_CNT:  lnk.shClocks = floorSix(`CET_SHREG_BASE + q + m + {7'h00, ~(q[0] ^ m[0])});
      SH_XROT_REG: lnk.shClocks = floorSix(`CET_XROT_REG_BASE + n + {7'h00, ~n[0]});
      SH_XROT_IMM: lnk.shClocks = floorSix(`CET_XROT_IMM_BASE + ni + {7'h00, ni[0]});
      SH_NONE:     lnk.shClocks = `CET_SHIFT_CLK;
    endcase
  end
endmodule : cet_shift_calc

// [sim/cet_bus_model.sv]
// far-side model: fetch step times on a bus with two-clock accesses
// bench picks which fetch steps an instruction carries
`timescale 1ns/1ps
module cet_bus_model
  import cet_pkg::*;
(
  // step selection
  input  wire logic         useImm,
  input  wire logic         useEa,
  // step times
  output cet_pkg::cet_time_s immTime,
  output cet_pkg::cet_time_s eaTime
);
  // immediate word: one two-clock prefetch
  assign immTime = useImm ? cet_time_s'{8'sh00, 8'sh00, 8'h02, 8'h02, 4'h0, 4'h1, 4'h0} : '0;
  // postincrement address step: head 1, two clocks
  assign eaTime = useEa ? cet_time_s'{8'sh01, 8'sh00, 8'h02, 8'h02, 4'h0, 4'h0, 4'h0} : '0;
endmodule : cet_bus_model

// [sim/cet_exec_timing_asserts.sv]
// checker on the execution timing model ports
// bound to the top module; figures hold for a zero address step
`timescale 1ns/1ps
module cet_exec_timing_asserts
  import cet_pkg::*;
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // request
  input wire logic               reqValid,
  input wire cet_pkg::cet_op_e   reqOp,
  input wire logic               reqLong,
  input wire logic               reqSrcDataReg,
  input wire cet_pkg::cet_time_s reqEaTime,
  // answer
  input wire logic               reqReady,
  input wire logic               ansValid,
  input wire logic signed [7:0]  ansHead,
  input wire logic signed [7:0]  ansTail,
  input wire logic [7:0]         ansTotalMin,
  input wire logic [7:0]         ansTotalMax,
  input wire logic [3:0]         ansWrites,
  input wire logic               ansUpperBound,
  input wire logic               ansSaveRun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic go;
  assign go = reqValid && reqReady && reqEaTime == '0;
  sequence busy_s; (!reqReady && !ansValid) [*4]; endsequence
  sequence answer_s; ansValid && reqReady; endsequence
  answer_lat_a: assert property (reqValid && reqReady |=> busy_s ##1 answer_s)
    else $error("answer off its cycle");
  ans_pulse_a: assert property (ansValid |=> !ansValid)
    else $error("answer pulse too long");
  reg_alu_a: assert property (go && reqOp == OP_ALU_REG |-> ##5 ansTotalMin == 8'h02 && ansHead == 8'sh00)
    else $error("register alu time wrong");
  word_mul_a: assert property (go && reqOp == OP_WORD_MUL |-> ##5 ansTotalMin == 8'h1A)
    else $error("word multiply time wrong");
  long_div_a: assert property (go && reqOp == OP_LONG_DIVS && reqSrcDataReg |-> ##5
    ansUpperBound && !ansSaveRun && ansTotalMax == 8'h3E) else $error("long divide time wrong");
  long_write_a: assert property (go && reqOp == OP_ALU_MEM && reqLong |-> ##5
    ansTail == 8'sh05 && ansTotalMin == 8'h07 && ansWrites == 4'h2) else $error("long write time wrong");
  shift_imm_a: assert property (go && reqOp == OP_SHIFT_IMM |-> ##5
    ansHead == 8'sh04 && ansTotalMin == 8'h06) else $error("immediate shift time wrong");
  shift_mem_a: assert property (go && reqOp == OP_SHIFT_MEM && !reqLong |-> ##5
    ansTail == 8'sh02 && ansWrites == 4'h1 && ansTotalMin == 8'h06) else $error("memory shift time wrong");
endmodule : cet_exec_timing_asserts
bind cet_exec_timing cet_exec_timing_asserts chk (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
  .reqLong(reqLong), .reqSrcDataReg(reqSrcDataReg), .reqEaTime(reqEaTime), .reqReady(reqReady), .ansValid(ansValid),
  .ansHead(ansHead), .ansTail(ansTail), .ansTotalMin(ansTotalMin), .ansTotalMax(ansTotalMax), .ansWrites(ansWrites),
  .ansUpperBound(ansUpperBound), .ansSaveRun(ansSaveRun));

// [sim/tb_cet_exec_timing.sv]
// bench for the execution timing model, one task per scenario
// bus model at the far side supplies fetch step times
`timescale 1ns/1ps
module tb_cet_exec_timing;
  import cet_pkg::*;
  logic              mclk, rst_n, reqValid, reqLong, reqSrcDataReg, useImm, useEa;
  logic              reqReady, ansValid, ansUpperBound, ansBusTolerant, ansSaveRun;
  logic [5:0]        reqCount;
  logic signed [7:0] ansHead, ansTail;
  logic [7:0]        ansTotalMin, ansTotalMax;
  logic [3:0]        ansReads, ansPrefetch, ansWrites;
  cet_op_e           reqOp;
  cet_time_s         eaT, immT;
  int                bad_count = 0, samples_checked = 0;
  cet_bus_model bus (.useImm(useImm), .useEa(useEa), .immTime(immT), .eaTime(eaT));
  cet_exec_timing #(.COUNT_W(6)) dut (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
    .reqLong(reqLong), .reqSrcDataReg(reqSrcDataReg), .reqCount(reqCount), .reqEaTime(eaT), .reqImmTime(immT),
    .reqReady(reqReady), .ansValid(ansValid), .ansHead(ansHead), .ansTail(ansTail), .ansTotalMin(ansTotalMin),
    .ansTotalMax(ansTotalMax), .ansReads(ansReads), .ansPrefetch(ansPrefetch), .ansWrites(ansWrites),
    .ansUpperBound(ansUpperBound), .ansBusTolerant(ansBusTolerant), .ansSaveRun(ansSaveRun));
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  // flags: long, source data register, immediate step, address step
  task automatic run(cet_op_e op, logic [3:0] f = 4'h0, logic [5:0] cnt = 6'h00);
    int n = 0;
    @(posedge mclk);
    reqValid <= 1'h1;
    reqOp <= op;
    {reqLong, reqSrcDataReg, useImm, useEa} <= f;
    reqCount <= cnt;
    @(posedge mclk);
    reqValid <= 1'h0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (ansValid !== 1'h1 && n < 12);
    chk("latency", 8'(n), 8'h05);
  endtask : run
  task automatic t_alu;
    run(OP_ALU_REG);
    chk("alu reg", ansTotalMin, 8'h02);
    run(OP_ALU_MEM);
    chk("alu mem tail", ansTail, 8'h03);
    run(OP_ALU_MEM, 4'h8);
    chk("alu long total", ansTotalMin, 8'h07);
    chk("alu long writes", ansWrites, 8'h02);
    run(OP_IMM_REG, 4'h2);
    chk("imm total", ansTotalMin, 8'h04);
    run(OP_ALU_FEA_REG, 4'h1);
    chk("fetch head", ansHead, 8'h01);
    $display("test alu done");
  endtask : t_alu
  task automatic t_muldiv;
    run(OP_WORD_MUL);
    chk("word mul", ansTotalMin, 8'h1A);
    run(OP_WORD_DIVU);
    chk("divu", ansTotalMin, 8'h20);
    run(OP_WORD_DIVS);
    chk("divs", ansTotalMin, 8'h2A);
    run(OP_LONG_DIVS, 4'hC);
    chk("ldivs max", ansTotalMax, 8'h3E);
    run(OP_LONG_MUL_PAIR, 4'h9);
    chk("lmul total", ansTotalMin, 8'h32);
    chk("lmul tolerant", ansBusTolerant, 8'h01);
    chk("lmul save", ansSaveRun, 8'h01);
    run(OP_LONG_MUL_ONE, 4'h1);
    chk("lmul one max", ansTotalMax, 8'h38);
    $display("test muldiv done");
  endtask : t_muldiv
  task automatic t_shift;
    run(OP_SHIFT_IMM, 4'h0, 6'h07);
    chk("shift imm", ansTotalMin, 8'h06);
    run(OP_SHIFT_REG, 4'h0, 6'h3F);
    chk("shift reg 63", ansTotalMin, 8'h16);
    run(OP_XROT_REG, 4'h0, 6'h3F);
    chk("xrot 63", ansTotalMin, 8'h42);
    run(OP_XROT_REG);
    chk("xrot 0", ansTotalMin, 8'h06);
    run(OP_SHIFT_MEM);
    chk("shift mem tail", ansTail, 8'h02);
    chk("shift mem total", ansTotalMin, 8'h06);
    run(OP_XROT_IMM, 4'h0, 6'h05);
    chk("xrot imm 5", ansTotalMin, 8'h08);
    $display("test shift done");
  endtask : t_shift
  task automatic t_misc;
    run(OP_BCD_MEM);
    chk("bcd mem", ansTotalMin, 8'h0C);
    chk("bcd reads", ansReads, 8'h02);
    run(OP_EXT_MEM);
    chk("ext mem", ansTotalMin, 8'h0A);
    run(OP_MEMORY_COMPARE_POSTINC);
    chk("memory_compare_postinc", ansTotalMin, 8'h08);
    run(OP_TAS_MEM);
    chk("tas writes", ansWrites, 8'h01);
    run(OP_TBL_R_REG);
    chk("tbl max", ansTotalMax, 8'h1E);
    chk("tbl pref", ansPrefetch, 8'h02);
    run(OP_ALTERNATE_SPACE_MOVE_LOAD, 4'h1);
    chk("alternate_space_move total", ansTotalMin, 8'h0F);
    chk("alternate_space_move tail", ansTail, 8'h01);
    chk("alternate_space_move save", ansSaveRun, 8'h01);
    $display("test misc done");
  endtask : t_misc
  task automatic final_report;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    rst_n = 1'h0;
    reqValid = 1'h0;
    reqOp = OP_ALU_REG;
    {reqLong, reqSrcDataReg, useImm, useEa} = 4'h0;
    reqCount = 6'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
    t_alu();
    t_muldiv();
    t_shift();
    t_misc();
    final_report();
  end
  initial
  begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule : tb_cet_exec_timing
